// ### logic/sdci_pkg.sv
// Purpose: Shared constants, types and burst arithmetic for the SDRAM command interface.
// Assumes: 50 MHz ref_clk, four banks, 32-bit data in four byte lanes.
// Notes: Mode register field positions follow the usual SDRAM layout.
`default_nettype none
package sdci_pkg;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int BANKS = 4;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  // Only the low row bit selects storage; higher rows alias onto it
  localparam int ROW_KEEP_W = 1;
  localparam int IDX_W = BANK_W + ROW_KEEP_W + COL_W;
  localparam int WORDS = 2048;

  // Command code is {ras, cas, we} sampled with chip select low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REFRESH = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE = 3'h3;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_STOP = 3'h6;

  // Address bit 10: precharge-all on precharge, auto precharge on read/write
  localparam int AP_BIT = 10;

  localparam int MODE_W = 10;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;
  localparam logic [9:0] MODE_RESET = 10'h030;

  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [2:0] CL_TWO = 3'h2;
  localparam logic [2:0] CL_THREE = 3'h3;

  localparam int REFRESH_ROWS = 4096;
  localparam int REFRESH_WINDOW_MS = 64;
  localparam int CLK_PERIOD_NS = 20;
  localparam int REFRESH_INTERVAL_NS = REFRESH_WINDOW_MS * 1000000 / REFRESH_ROWS;
  // Longest spacing, so rounded down
  localparam int SR_INTERVAL_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int SR_CNT_W = 10;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_SUSPEND = 2'h1,
    PWR_DOWN = 2'h3,
    PWR_SELF = 2'h2
  } sdci_pwr_t;

  function automatic logic [COL_W-1:0] burst_mask(input logic [2:0] blCode);
    case (blCode)
      BL_2: burst_mask = 8'h01;
      BL_4: burst_mask = 8'h03;
      BL_8: burst_mask = 8'h07;
      BL_FULL: burst_mask = 8'hFF;
      default: burst_mask = 8'h00;
    endcase
  endfunction

  // Carry never leaves the burst's aligned block; full page has no interleave
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
      input logic [COL_W-1:0] idx, input logic [2:0] blCode, input logic inter);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] low;
    m = burst_mask(blCode);
    low = (inter && blCode != BL_FULL) ? (start ^ idx) : COL_W'(start + idx);
    burst_col = (start & ~m) | (low & m);
  endfunction
endpackage
`default_nettype wire

// ### logic/sdci_array.sv
// Purpose: Cell storage with per-byte write enables and combinational read.
// Assumes: Write and read use the same index in one cycle.
// Notes: Flip-flop storage, no reset; contents are undefined until written.
`timescale 1ns/1ps
`default_nettype none
module sdci_array import sdci_pkg::*; (
  input wire logic clk,
  input wire logic en,
  input wire logic [LANES-1:0] byteWe,
  input wire logic [IDX_W-1:0] idx,
  input wire logic [DATA_W-1:0] wData,
  output logic [DATA_W-1:0] rData
);
  logic [DATA_W-1:0] mem_r [WORDS];

  always_ff @(posedge clk) begin
    if (en) begin
      for (int i = 0; i < LANES; i++) begin
        if (byteWe[i]) begin
          mem_r[idx][i*BYTE_W +: BYTE_W] <= wData[i*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  assign rData = mem_r[idx];
endmodule
`default_nettype wire

// ### logic/sdci_read_pipe.sv
// Purpose: Read data latency pipeline and byte-lane output enables.
// Assumes: capValid/capData arrive in the cycle the column is accessed.
// Notes: Mask latency is fixed at two cycles whatever the read latency.
`timescale 1ns/1ps
`default_nettype none
module sdci_read_pipe import sdci_pkg::*; (
  input wire logic clk,
  input wire logic rstN,
  input wire logic en,
  input wire logic capValid,
  input wire logic [DATA_W-1:0] capData,
  input wire logic [LANES-1:0] dqm,
  input wire logic latTwo,
  output logic [DATA_W-1:0] dqOut,
  output logic [LANES-1:0] dqOe
);
  logic v0_r;
  logic v1_r;
  logic [DATA_W-1:0] d0_r;
  logic [DATA_W-1:0] d1_r;
  logic [LANES-1:0] m0_r;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= '0;
      d1_r <= '0;
      m0_r <= '0;
    end else if (en) begin
      v0_r <= capValid;
      d0_r <= capData;
      v1_r <= v0_r;
      d1_r <= d0_r;
      m0_r <= dqm;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dqOut <= '0;
      dqOe <= '0;
    end else if (en) begin
      if (latTwo) begin
        dqOut <= d0_r;
        dqOe <= {LANES{v0_r}} & ~m0_r;
      end else begin
        dqOut <= d1_r;
        dqOe <= {LANES{v1_r}} & ~m0_r;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/sdci_command_interface.sv
// Purpose: Pin-level command decoder, bank state, burst engine and power modes of the SDRAM.
// Assumes: Pins are synchronous to ref_clk; controller keeps the refresh schedule.
// Notes: Storage keeps only the low row bit, so higher rows alias.
// Overview of operation
// R1: Bursts of 1, 2, 4, 8 or full page within the open row.
// R2: Internal counter generates later burst columns from the starting column.
// R3: A new read column is accepted every cycle, restarting the burst.
// R4: Mode register holds burst length, read latency and burst ordering.
// R5: Read latency is programmable to two or three cycles.
// R6: Burst columns run sequential or interleaved by mode setting.
// R7: Option where reads burst but each write stores one word.
// R8: Controller issues 4096 refreshes every 64 ms.
// R9: Auto precharge at end of access and explicit precharge command.
// R10: Row uses address lines 0 to 10, column lines 0 to 7; the bank row register keeps only row line 0.
// R11: Address line 10 at precharge selects all banks or one bank.
// R12: Two bank select inputs pick one of four banks.
// R13: Chip select high ignores new commands; running bursts continue.
// R14: RAS, CAS and WE levels at the rising edge select the command.
// R15: Mask high during read floats that byte lane two cycles later.
// R16: Mask high during write blocks that byte in the same cycle.
// R17: Each of four mask inputs governs one byte lane.
// R18: All inputs are captured on the rising clock edge.
// R19: Clock enable low enters power-down, clock suspend or self refresh.
// R20: Auto refresh by command and internally timed self refresh.
// R21: Data lines carry write or read data, never both in a cycle.
// R22: Banks open and close independently for interleaved access.
// R23: Read is CS and CAS low with RAS and WE high.
// R24: Write is CS, CAS and WE low with RAS high.
// R25: Write data comes with the command, then one word each edge.
// R26: Mode set is all strobes low; address supplies the settings.
// R27: Clock enable high resumes operation and leaves low-power modes.
// R28: Read data follows latency, one word per cycle over the burst.
`timescale 1ns/1ps
`default_nettype none
module sdci_command_interface import sdci_pkg::*; (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [ROW_W-1:0] addr,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic [LANES-1:0] dqm,
  input wire logic [DATA_W-1:0] dqIn,
  output logic [DATA_W-1:0] dqOut,
  output logic [LANES-1:0] dqOe,
  output logic [BANKS-1:0] bankOpen,
  output logic [2:0] burstLenCode,
  output logic [2:0] casLatency,
  output logic burstInterleave,
  output logic singleWrite,
  output logic burstBusy,
  output logic [1:0] powerState,
  output logic [ROW_W-1:0] refreshRow
);
  logic [1:0] rstSync_r;
  logic rstN;
  sdci_pwr_t pwr_r;
  logic [MODE_W-1:0] modeReg_r;
  logic [BANKS-1:0] bankOpen_r;
  logic [ROW_KEEP_W-1:0] bankRow_r [BANKS];
  logic active_r;
  logic write_r;
  logic ap_r;
  logic [BANK_W-1:0] bank_r;
  logic [COL_W-1:0] start_r;
  logic [COL_W-1:0] idx_r;
  logic [SR_CNT_W-1:0] srCnt_r;
  logic [ROW_W-1:0] refreshRow_r;
  logic en;
  logic sel;
  logic [2:0] cmd;
  logic [BANK_W-1:0] bankIn;
  logic mrsGo, refGo, preGo, actGo, wrGo, rdGo, stopGo, go;
  logic curWrite, curAp, curActive, acc, lastWord;
  logic [BANK_W-1:0] curBank;
  logic [COL_W-1:0] curStart, curIdx, curCol, curLast;
  logic [IDX_W-1:0] memIdx;
  logic [LANES-1:0] byteWe;
  logic [DATA_W-1:0] rdWord;
  logic srTick;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstSync_r <= 2'h0;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end
  assign rstN = rstSync_r[1];

  // Clock enable freezes the core; only power tracking and self refresh run
  assign en = cke && pwr_r == PWR_ACTIVE; // [R19]
  assign cmd = {rasN, casN, weN}; // [R14]
  assign bankIn = {bank_select_high, bank_select_low}; // [R12]
  assign sel = en && !csN; // [R13] [R18]
  assign mrsGo = sel && cmd == CMD_MRS; // [R26]
  assign refGo = sel && cmd == CMD_REFRESH; // [R20]
  assign preGo = sel && cmd == CMD_PRECHARGE; // [R9]
  assign actGo = sel && cmd == CMD_ACTIVATE;
  assign wrGo = sel && cmd == CMD_WRITE; // [R24]
  assign rdGo = sel && cmd == CMD_READ; // [R23]
  assign stopGo = sel && cmd == CMD_STOP;
  assign go = rdGo || wrGo;

  // A new column command overrides whatever burst is running
  assign curStart = go ? addr[COL_W-1:0] : start_r; // [R3] [R10]
  assign curIdx = go ? 8'h00 : idx_r;
  assign curBank = go ? bankIn : bank_r; // [R12]
  assign curWrite = go ? wrGo : write_r;
  assign curAp = go ? addr[AP_BIT] : ap_r;
  assign curActive = en && (go || active_r);
  // Stop and precharge end the burst before this cycle's access
  assign acc = curActive && !stopGo && !preGo; // [R13]
  assign curCol = burst_col(curStart, curIdx, modeReg_r[MODE_BL_LSB +: 3],
                            modeReg_r[MODE_BT_BIT]); // [R2] [R6]
  assign curLast = (curWrite && modeReg_r[MODE_WB_BIT]) ? 8'h00 :
                   burst_mask(modeReg_r[MODE_BL_LSB +: 3]); // [R1] [R7]
  // Full page wraps until stopped
  // Single write ends at its first word even in full-page mode
  assign lastWord = (curWrite && modeReg_r[MODE_WB_BIT]) ||
                    (curIdx == curLast && modeReg_r[MODE_BL_LSB +: 3] != BL_FULL); // [R7]
  assign memIdx = {curBank, bankRow_r[curBank], curCol};
  assign byteWe = {LANES{acc && curWrite}} & ~dqm; // [R16] [R17] [R25]

  sdci_array u_array (
    .clk(ref_clk),
    .en(en),
    .byteWe(byteWe),
    .idx(memIdx),
    .wData(dqIn),
    .rData(rdWord)
  );

  // Read words are only captured on non-write cycles
  sdci_read_pipe u_pipe (
    .clk(ref_clk),
    .rstN(rstN),
    .en(en),
    .capValid(acc && !curWrite), // [R21] [R28]
    .capData(rdWord),
    .dqm(dqm), // [R15]
    .latTwo(modeReg_r[MODE_CL_LSB +: 3] == CL_TWO), // [R5]
    .dqOut(dqOut),
    .dqOe(dqOe)
  );

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      modeReg_r <= MODE_RESET;
    end else if (mrsGo) begin
      modeReg_r <= addr[MODE_W-1:0]; // [R4] [R26]
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      active_r <= 1'b0;
      write_r <= 1'b0;
      ap_r <= 1'b0;
      bank_r <= '0;
      start_r <= '0;
      idx_r <= '0;
    end else if (en) begin
      if (acc && !lastWord) begin
        active_r <= 1'b1;
        idx_r <= COL_W'(curIdx + 8'h01); // [R2] [R28]
      end else begin
        active_r <= 1'b0;
      end
      if (go) begin
        write_r <= wrGo;
        ap_r <= addr[AP_BIT];
        bank_r <= bankIn;
        start_r <= addr[COL_W-1:0];
      end
    end
  end

  // Each bank keeps its own open flag and row
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      bankOpen_r <= '0;
      for (int b = 0; b < BANKS; b++) begin
        bankRow_r[b] <= '0;
      end
    end else if (en) begin
      // Auto precharge must not be lost to another bank's activate
      if (acc && lastWord && curAp) begin
        bankOpen_r[curBank] <= 1'b0; // [R9]
      end
      if (actGo) begin
        bankOpen_r[bankIn] <= 1'b1; // [R22] [R12]
        bankRow_r[bankIn] <= addr[ROW_KEEP_W-1:0]; // [R10]
      end else if (preGo && addr[AP_BIT]) begin
        bankOpen_r <= '0; // [R11]
      end else if (preGo) begin
        bankOpen_r[bankIn] <= 1'b0; // [R11] [R9]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pwr_r <= PWR_ACTIVE;
    end else begin
      case (pwr_r)
        PWR_ACTIVE: begin
          if (!cke && !csN && cmd == CMD_REFRESH) begin
            pwr_r <= PWR_SELF; // [R19] [R20]
          end else if (!cke && active_r) begin
            pwr_r <= PWR_SUSPEND; // [R19]
          end else if (!cke) begin
            pwr_r <= PWR_DOWN; // [R19]
          end
        end
        default: begin
          if (cke) begin
            pwr_r <= PWR_ACTIVE; // [R27]
          end
        end
      endcase
    end
  end

  // Self refresh paces itself at the controller's average interval
  assign srTick = pwr_r == PWR_SELF && srCnt_r == SR_CNT_W'(SR_INTERVAL_CYCLES - 1); // [R8]

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      srCnt_r <= '0;
    end else if (pwr_r != PWR_SELF || srTick) begin
      srCnt_r <= '0;
    end else begin
      srCnt_r <= SR_CNT_W'(srCnt_r + 10'h001);
    end
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      refreshRow_r <= '0;
    end else if (refGo || srTick) begin
      refreshRow_r <= ROW_W'(refreshRow_r + 11'h001); // [R20]
    end
  end

  assign bankOpen = bankOpen_r;
  assign burstLenCode = modeReg_r[MODE_BL_LSB +: 3];
  assign casLatency = modeReg_r[MODE_CL_LSB +: 3];
  assign burstInterleave = modeReg_r[MODE_BT_BIT];
  assign singleWrite = modeReg_r[MODE_WB_BIT];
  assign burstBusy = active_r;
  assign powerState = pwr_r;
  assign refreshRow = refreshRow_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  sequence rdTwoSeq;
    rdGo && casLatency == CL_TWO && dqm == 4'h0 ##1 cke [*2];
  endsequence

  sequence rdThreeSeq;
    rdGo && casLatency == CL_THREE ##1 cke [*3];
  endsequence

  rd_latency_two_a: assert property (rdTwoSeq |-> dqOe == 4'hF) // [R5]
    else $error("read data not driven two cycles after read");
  rd_latency_three_a: assert property (rdThreeSeq |-> dqOe == ~$past(dqm, 2)) // [R28]
    else $error("first read word lanes wrong at latency three");
  dqm_float_a: assert property (dqm[3] ##1 cke [*2] |-> !dqOe[3]) // [R15]
    else $error("masked lane still driven");
  seq_burst_col_a: assert property (rdGo && burstLenCode == BL_4 && !burstInterleave
      && cke ##1 cke |-> curCol[1:0] == 2'($past(addr[1:0]) + 2'h1)) // [R2]
    else $error("sequential burst column wrong");
  ilv_burst_col_a: assert property (rdGo && burstLenCode == BL_8 && burstInterleave
      && cke ##1 cke [*2] |-> curCol[2:0] == ($past(addr[2:0], 2) ^ 3'h2)) // [R6]
    else $error("interleaved burst column wrong");
  cs_ignore_a: assert property (csN && !active_r |=> bankOpen_r == $past(bankOpen_r)
      && modeReg_r == $past(modeReg_r)) // [R13]
    else $error("command taken with chip select high");
  pre_all_a: assert property (preGo && addr[AP_BIT] |=> bankOpen_r == 4'h0) // [R11]
    else $error("precharge all left a bank open");
  act_bank_a: assert property (actGo |=> bankOpen_r[$past(bankIn)]) // [R12]
    else $error("activated bank not open");
  wr_mask_a: assert property (acc && curWrite && dqm[0]
      |=> u_array.mem_r[$past(memIdx)][7:0] == $past(rdWord[7:0])) // [R16]
    else $error("masked byte was written");
  single_wr_a: assert property (wrGo && singleWrite |=> !active_r) // [R7]
    else $error("single write mode continued a burst");
  self_ref_a: assert property (pwr_r == PWR_ACTIVE && !cke && !csN && cmd == CMD_REFRESH
      |=> pwr_r == PWR_SELF ##1 (cke || pwr_r == PWR_SELF)) // [R19]
    else $error("self refresh not entered");
  wake_a: assert property (pwr_r != PWR_ACTIVE && cke |=> pwr_r == PWR_ACTIVE) // [R27]
    else $error("no resume when clock enable returned");
  burst_stop_a: assert property (stopGo |=> !burstBusy) // [R1]
    else $error("burst continued after stop");
  ap_close_a: assert property (acc && lastWord && curAp && !(actGo && bankIn == curBank)
      |=> !bankOpen_r[$past(curBank)]) // [R9]
    else $error("auto precharge left the bank open");
endmodule
`default_nettype wire

// ### bench/sdci_ctrl_model.sv
// Purpose: Controller-side pin driver and DQ wire resolution for the bench.
// Assumes: Bench changes requests by NBA just after rising edges.
// Notes: Lanes nobody drives show the inverse of their last level.
`timescale 1ns/1ps
`default_nettype none
module sdci_ctrl_model import sdci_pkg::*; (
  input wire logic clk,
  input wire logic reqCke,
  input wire logic reqSel,
  input wire logic [2:0] reqCmd,
  input wire logic [ROW_W-1:0] reqAddr,
  input wire logic [1:0] reqBank,
  input wire logic [LANES-1:0] reqDqm,
  input wire logic reqDrive,
  input wire logic [DATA_W-1:0] reqData,
  input wire logic [DATA_W-1:0] dqOut,
  input wire logic [LANES-1:0] dqOe,
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [ROW_W-1:0] addr,
  output logic bankSelectLow,
  output logic bankSelectHigh,
  output logic [LANES-1:0] dqm,
  output logic [DATA_W-1:0] dqWire
);
  logic [DATA_W-1:0] lastWire = '0;
  assign cke = reqCke;
  assign csN = ~reqSel;
  assign {rasN, casN, weN} = reqCmd;
  assign addr = reqAddr;
  assign {bankSelectHigh, bankSelectLow} = reqBank;
  assign dqm = reqDqm;
  // Released lanes toggle so a stale level is never mistaken for data
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      if (dqOe[l]) dqWire[l*8 +: 8] = dqOut[l*8 +: 8];
      else if (reqDrive) dqWire[l*8 +: 8] = reqData[l*8 +: 8];
      else dqWire[l*8 +: 8] = ~lastWire[l*8 +: 8];
    end
  end
  always_ff @(posedge clk) begin
    lastWire <= dqWire;
  end
endmodule
`default_nettype wire

// ### bench/sdci_command_interface_bench.sv
// Purpose: Self-checking bench for the SDRAM command interface.
// Assumes: Pins set just after a rising edge are sampled at the next one.
// Notes: Deselected cycles carry a precharge-all code, which must be ignored.
`timescale 1ns/1ps
`default_nettype none
module sdci_command_interface_bench import sdci_pkg::*;;
  logic refClk;
  logic resetn = 1'h0;
  logic reqCke = 1'h1, reqSel = 1'h0, reqDrive = 1'h0, useCke = 1'h1;
  logic [2:0] reqCmd = 3'h7;
  logic [ROW_W-1:0] reqAddr = '0, addr, refreshRow;
  logic [1:0] reqBank = 2'h0, useBank = 2'h1, powerState;
  logic [LANES-1:0] reqDqm = 4'hF, dqm, dqOe;
  logic [DATA_W-1:0] reqData = '0, dqWire, dqOut;
  logic cke, csN, rasN, casN, weN, bsLow, bsHigh;
  logic [BANKS-1:0] bankOpen;
  logic [2:0] burstLenCode, casLatency;
  logic burstInterleave, singleWrite, burstBusy;
  logic [31:0] shadow [256];
  logic [9:0] modes [6] = '{10'h020, 10'h039, 10'h022, 10'h03B, 10'h222, 10'h037};
  int blTab [6] = '{1, 2, 4, 8, 4, 256};
  logic [7:0] rc [3] = '{8'h10, 8'h21, 8'h20};
  int n_fail = 0;
  int cmp_count = 0;

  sdci_ctrl_model ctrl (.clk(refClk), .reqCke(reqCke), .reqSel(reqSel), .reqCmd(reqCmd),
    .reqAddr(reqAddr), .reqBank(reqBank), .reqDqm(reqDqm), .reqDrive(reqDrive),
    .reqData(reqData), .dqOut(dqOut), .dqOe(dqOe), .cke(cke), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .addr(addr), .bankSelectLow(bsLow), .bankSelectHigh(bsHigh),
    .dqm(dqm), .dqWire(dqWire));
  sdci_command_interface dut (.ref_clk(refClk), .resetn(resetn), .cke(cke), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .addr(addr), .bank_select_low(bsLow),
    .bank_select_high(bsHigh), .dqm(dqm), .dqIn(dqWire), .dqOut(dqOut), .dqOe(dqOe),
    .bankOpen(bankOpen), .burstLenCode(burstLenCode), .casLatency(casLatency),
    .burstInterleave(burstInterleave), .singleWrite(singleWrite), .burstBusy(burstBusy),
    .powerState(powerState), .refreshRow(refreshRow));

  initial begin
    refClk = 1'h0;
    forever #10 refClk = ~refClk;
  end

  task automatic print_verdict;
    $display("%0d comparisons, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic endTest(input string nm);
    $display("%s finished, %0d mismatches", nm, n_fail);
  endtask

  task automatic issue(input logic sel, input logic [2:0] c, input logic [10:0] a,
      input logic [3:0] m, input logic drv, input logic [31:0] d);
    @(posedge refClk);
    reqCke <= useCke;
    reqSel <= sel;
    reqCmd <= c;
    reqAddr <= a;
    reqBank <= useBank;
    reqDqm <= m;
    reqDrive <= drv;
    reqData <= d;
  endtask

  task automatic cmd(input logic [2:0] c, input logic [10:0] a);
    issue(1'h1, c, a, 4'h0, 1'h0, 32'h0);
  endtask

  task automatic idle(input logic [3:0] m);
    issue(1'h0, CMD_PRECHARGE, 11'h400, m, 1'h0, 32'h0);
  endtask

  function automatic logic [7:0] colOf(input logic [7:0] s, input int i, input int n,
      input logic il);
    logic [7:0] m;
    m = 8'(n - 1);
    colOf = (s & ~m) | (((il && n != 256) ? (s ^ 8'(i)) : 8'(s + i)) & m);
  endfunction

  function automatic logic [31:0] pat(input int k, input int i);
    pat = {8'(k), 8'(i), 8'(i) ^ 8'h5A, 8'(k * 7 + i)};
  endfunction

  task automatic wrBurst(input logic [7:0] col, input int bl, input int nW, input logic one,
      input int k, input logic il);
    logic [3:0] m;
    logic [31:0] d;
    for (int i = 0; i < nW; i++) begin
      m = (i == 1 && k != 0) ? 4'h1 : 4'h0;
      d = pat(k, i);
      if (i == 0) issue(1'h1, CMD_WRITE, {3'h0, col}, m, 1'h1, d);
      else issue(1'h0, CMD_PRECHARGE, 11'h400, m, 1'h1, d);
      for (int l = 0; l < LANES; l++) begin
        if ((i == 0 || !one) && !m[l]) shadow[colOf(col, i, bl, il)][l*8 +: 8] = d[l*8 +: 8];
      end
    end
    if (bl == 256) cmd(CMD_STOP, 11'h000);
  endtask

  task automatic rdChk(input logic [7:0] col, input int bl, input int lat, input logic il,
      input logic ap);
    int n;
    int idx;
    logic [3:0] oe;
    logic [31:0] lm;
    n = (bl == 256) ? 8 : bl;
    issue(1'h1, CMD_READ, {ap, 2'h0, col}, 4'h0, 1'h0, 32'h0);
    for (int j = 1; j <= n + lat; j++) begin
      if (bl == 256 && j == n) cmd(CMD_STOP, 11'h000);
      else idle((j == 1) ? 4'h8 : 4'h0);
      #1;
      idx = j - lat;
      oe = (idx >= 0 && idx < n) ? ((j == 3) ? 4'h7 : 4'hF) : 4'h0;
      lm = {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
      chk("dqOe", 32'(oe), 32'(dqOe));
      if (oe != 4'h0) chk("dqOut", shadow[colOf(col, idx, bl, il)] & lm, dqOut & lm);
    end
    if (ap) chk("bankOpen", 32'h0, 32'(bankOpen & 4'h2));
  endtask

  initial begin
    repeat (20000) @(posedge refClk);
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge refClk);
    resetn <= 1'h1;
    repeat (4) idle(4'h0);
    #1;
    chk("resetState", 32'h0C000000, 32'({casLatency, burstLenCode, burstInterleave,
      singleWrite, powerState, bankOpen, dqOe, refreshRow}));
    endTest("reset");
    cmd(CMD_MRS, 11'h037);
    cmd(CMD_ACTIVATE, 11'h000);
    wrBurst(8'h00, 256, 256, 1'h0, 0, 1'h0);
    endTest("fill");
    for (int k = 0; k < 6; k++) begin
      cmd(CMD_MRS, {1'h0, modes[k]});
      cmd(CMD_ACTIVATE, 11'h000);
      #1;
      chk("mode", 32'({modes[k][9], modes[k][6:0]}), 32'({singleWrite, casLatency,
        burstInterleave, burstLenCode}));
      wrBurst(8'h2D, blTab[k], (blTab[k] == 256) ? 8 : blTab[k], modes[k][9], k + 1,
        modes[k][3]);
      rdChk(8'h2D, blTab[k], 32'(modes[k][6:4]), modes[k][3], k == 2);
      endTest("burstMode");
    end
    cmd(CMD_MRS, 11'h021);
    cmd(CMD_READ, 11'h010);
    cmd(CMD_READ, 11'h021);
    for (int j = 0; j < 4; j++) begin
      idle(4'h0);
      #1;
      if (j < 3) chk("dqOut", shadow[rc[j]], dqOut);
      else chk("dqOe", 32'h0, 32'(dqOe));
    end
    endTest("columnPerCycle");
    for (int b = 0; b < 4; b++) begin
      useBank = 2'(b);
      cmd(CMD_ACTIVATE, 11'h005);
    end
    useBank = 2'h2;
    cmd(CMD_PRECHARGE, 11'h000);
    #1;
    chk("bankOpen", 32'hF, 32'(bankOpen));
    cmd(CMD_PRECHARGE, 11'h400);
    #1;
    chk("bankOpen", 32'hB, 32'(bankOpen));
    idle(4'h0);
    #1;
    chk("bankOpen", 32'h0, 32'(bankOpen));
    endTest("banks");
    cmd(CMD_REFRESH, 11'h000);
    useCke = 1'h0;
    idle(4'h0);
    #1;
    chk("refreshRow", 32'h1, 32'(refreshRow));
    idle(4'h0);
    #1;
    chk("powerState", 32'h3, 32'(powerState));
    useCke = 1'h1;
    repeat (2) idle(4'h0);
    #1;
    chk("powerState", 32'h0, 32'(powerState));
    useCke = 1'h0;
    cmd(CMD_REFRESH, 11'h000);
    repeat (1600) idle(4'h0);
    #1;
    chk("selfRefresh", 32'h1003, 32'({powerState, refreshRow}));
    useCke = 1'h1;
    // Command on the waking edge is dropped, so the burst length stays at two
    cmd(CMD_MRS, 11'h023);
    cmd(CMD_READ, 11'h040);
    cmd(CMD_READ, 11'h040);
    #1;
    chk("wakeState", 32'h1, 32'({powerState, burstLenCode}));
    useCke = 1'h0;
    repeat (2) idle(4'h0);
    #1;
    chk("powerState", 32'h1, 32'(powerState));
    chk("burstBusy", 32'h1, 32'(burstBusy));
    useCke = 1'h1;
    repeat (14) idle(4'h0);
    #1;
    chk("dqOe", 32'h0, 32'({powerState, dqOe}));
    chk("burstBusy", 32'h0, 32'(burstBusy));
    endTest("power");
    print_verdict();
  end
endmodule
`default_nettype wire
